// ===== hw/bml_defines.svh
// register offsets, field positions, reset values and timing counts of the log configuration block
`ifndef BML_DEFINES_SVH
`define BML_DEFINES_SVH

`define BML_OFS_MODE_FILT   8'hD0
`define BML_OFS_BUF_START   8'hD4
`define BML_OFS_BUF_END     8'hD8
`define BML_OFS_BUF_POS     8'hDC
`define BML_OFS_TIME_TAG    8'hE0

`define BML_MODE_FILT_RST   19'h7FFFF
`define BML_MODE_RSVD_RD    13'h1FFF
`define BML_START_RST       29'h00000000
`define BML_END_RST         19'h00000
`define BML_POS_RST         19'h00000
`define BML_END_LOW_RD      3'h7
`define BML_ALIGN_LOW_RD    3'h0
`define BML_TT_RES_RST      8'h00
`define BML_TT_VAL_RST      24'h000000

`define BML_SA_MODE_LO      5'h00
`define BML_SA_MODE_HI      5'h1F
`define BML_RT_BCAST        5'h1F

`define BML_MCB_SEL_SHUT_BC  5'h12
`define BML_MCB_SEL_SHUT     5'h11
`define BML_MCB_LAST_CMD     5'h10
`define BML_MCB_STATUS_WORD  5'h0F
`define BML_MCB_RESET_BC     5'h0E
`define BML_MCB_RESET        5'h0D
`define BML_MCB_FLAG_INH_BC  5'h0C
`define BML_MCB_FLAG_INH     5'h0B
`define BML_MCB_SELF_TEST_BC 5'h0A
`define BML_MCB_SELF_TEST    5'h09
`define BML_MCB_BUS_CTRL     5'h08
`define BML_MCB_BIT_WORD     5'h07
`define BML_MCB_VECTOR_WORD  5'h06
`define BML_MCB_SHUT_BC      5'h05
`define BML_MCB_SHUT         5'h04
`define BML_MCB_SYNC_DATA_BC 5'h03
`define BML_MCB_SYNC_DATA    5'h02
`define BML_MCB_SYNC_BC      5'h01
`define BML_MCB_SYNC         5'h00

`define BML_CLK_PERIOD_NS   100
`define BML_US_NS           1000
`define BML_CYC_PER_US      (`BML_US_NS / `BML_CLK_PERIOD_NS)

`endif

// ===== hw/bml_pkg.sv
// types shared by the log configuration block
package bml_pkg;

    typedef enum logic [4:0] {
        MC_BUS_CTRL = 5'h00, MC_SYNC = 5'h01, MC_STATUS_WORD = 5'h02, MC_SELF_TEST = 5'h03,
        MC_SHUT = 5'h04, MC_SHUT_OVR = 5'h05, MC_FLAG_INH = 5'h06, MC_FLAG_INH_OVR = 5'h07,
        MC_RESET = 5'h08, MC_VECTOR_WORD = 5'h10, MC_SYNC_DATA = 5'h11, MC_LAST_CMD = 5'h12,
        MC_BIT_WORD = 5'h13, MC_SEL_SHUT = 5'h14, MC_SEL_SHUT_OVR = 5'h15
    } bml_mode_code_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bml_reg_req_t;

    typedef struct packed {
        logic [4:0]  rt_addr;
        logic [4:0]  sub_addr;
        logic [4:0]  mode_code;
        logic [31:0] word;
    } bml_xfer_t;

    typedef struct packed {
        bml_xfer_t   xfer;
        logic [23:0] tag;
    } bml_entry_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [63:0] data;
    } bml_memwr_t;

endpackage : bml_pkg

// ===== hw/bml_fifo.sv
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ns
module bml_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready_ff,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wp_ff;
    logic [AW-1:0]    rp_ff;
    logic [AW:0]      cnt_ff;
    logic [AW:0]      nxt_cnt;
    logic             push;
    logic             pop;

    assign push     = in_valid && in_ready_ff;
    assign pop      = out_valid && out_ready;
    assign out_valid = cnt_ff != '0;
    assign out_data = mem_ff[rp_ff];

    always_comb begin
        nxt_cnt = cnt_ff;
        if (push && !pop) nxt_cnt = cnt_ff + (AW+1)'(1);
        if (pop && !push) nxt_cnt = cnt_ff - (AW+1)'(1);
    end

    always_ff @(posedge clk) begin
        if (push) mem_ff[wp_ff] <= in_data;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_ff       <= '0;
            rp_ff       <= '0;
            cnt_ff      <= '0;
            in_ready_ff <= 1'b1;
        end else begin
            if (push) wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + AW'(1);
            if (pop) rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + AW'(1);
            cnt_ff      <= nxt_cnt;
            in_ready_ff <= nxt_cnt != (AW+1)'(DEPTH);
        end
    end
endmodule : bml_fifo

// ===== hw/bml_time_tag.sv
// free running time tag counter with a microsecond prescaler and a programmable tick period
`timescale 1ns/1ns
`include "bml_defines.svh"
module bml_time_tag #(
    parameter int unsigned CYC_PER_US = `BML_CYC_PER_US
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        load,
    input  wire logic [7:0]  load_res,
    input  wire logic [23:0] load_val,
    output logic [7:0]       res_ff,
    output logic [23:0]      value_ff
);
    localparam int unsigned UW = $clog2(CYC_PER_US + 1);
    logic [UW-1:0] us_cnt_ff;
    logic          us_tick_ff;
    logic [7:0]    per_cnt_ff;
    logic          step;

    assign step = us_tick_ff && (per_cnt_ff >= res_ff);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            us_cnt_ff  <= '0;
            us_tick_ff <= 1'b0;
        end else begin
            us_cnt_ff  <= (us_cnt_ff == UW'(CYC_PER_US-1)) ? '0 : us_cnt_ff + UW'(1);
            us_tick_ff <= us_cnt_ff == UW'(CYC_PER_US-1);
        end
    end

    // period is the resolution field plus one microseconds
    always_ff @(posedge clk) begin
        if (!rst_n) per_cnt_ff <= 8'h00;
        else if (step) per_cnt_ff <= 8'h00;
        else if (us_tick_ff) per_cnt_ff <= per_cnt_ff + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_ff   <= `BML_TT_RES_RST;
            value_ff <= `BML_TT_VAL_RST;
        end else if (load) begin
            res_ff   <= load_res;
            value_ff <= load_val;
        end else if (step) begin
            value_ff <= value_ff + 24'h000001;
        end
    end

    chk_tt_step_inc : assert property (@(posedge clk) disable iff (!rst_n)
        step && !load |=> value_ff == $past(value_ff) + 24'h000001)
        else $error("time tag did not advance on its tick");
endmodule : bml_time_tag

// ===== hw/bml_log_config.sv
// register bank, entry filter and ring pointer logic for the bus monitor log
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`include "bml_defines.svh"
// Overview of operation
// - a mode command on subaddress 0 is logged only while bit 0 of the subaddress filter is one.
// - bits 18 to 0 of the mode filter each enable one mode code or a code with its override, bits 31 to 19 are reserved.
// - filter bits 18 to 12 pick selected shutdown (bcast/addr), last command, status, reset (bcast/addr), flag bcast.
// - filter bits 11 to 0 pick flag, self test, bus control, bit word, vector word, shutdown and the syncs.
// - the start register holds the lowest ring address, 8-byte aligned, low three bits read zero.
// - the end register holds the highest ring address and only its bits 21 to 3 are writable.
// - bits 31 to 22 of end and position read back as those of the start register.
// - the low three bits of the end register always read one.
// - the position register points at the next entry to write, only bits 21 to 3 writable.
// - the low three bits of the position register always read zero.
// - bits 31 to 24 of the time tag register hold the tick period in microseconds minus one.
// - bits 23 to 0 of the time tag register read the running counter and may be overwritten.
// - nothing is logged unless the monitor enable is one.
// - with halt on wrap set, a wrap from end to start clears the enable and stops logging.
// - a transfer is logged only if the terminal address filter bit of its address is one.
module bml_log_config #(
    parameter int unsigned FIFO_DEPTH = 8,
    parameter int unsigned CYC_PER_US = `BML_CYC_PER_US
) (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire bml_pkg::bml_reg_req_t reg_req,
    output logic [31:0]                reg_rdata_ff,
    input  wire logic                  monitor_enable,
    input  wire logic                  halt_on_wrap,
    input  wire logic [31:0]           terminal_address_log_filter,
    input  wire logic [31:0]           subaddress_log_filter,
    output logic                       enable_clear_ff,
    input  wire logic                  xfer_valid,
    input  wire bml_pkg::bml_xfer_t    xfer_data,
    output logic                       xfer_ready,
    output bml_pkg::bml_memwr_t        mem_wr_ff,
    output logic                       mem_wr_valid_ff,
    input  wire logic                  mem_wr_ready
);
    import bml_pkg::*;

    logic [18:0] mode_filt_ff;
    logic [28:0] start_ff;
    logic [18:0] end_ff;
    logic [18:0] pos_ff;
    logic        halted_ff;
    logic [7:0]  tt_res;
    logic [23:0] tt_val;
    logic        wr_mode;
    logic        wr_start;
    logic        wr_end;
    logic        wr_pos;
    logic        wr_tt;
    logic [31:0] nxt_rdata;
    bml_entry_t  fifo_in;
    bml_entry_t  pop_entry;
    logic        pop_valid;
    logic        pop_ready;
    logic        pop;
    logic        is_mode;
    logic        bcast;
    logic [5:0]  mc_sel;
    logic        hit_rt;
    logic        hit_sa;
    logic        hit_mc;
    logic        log_ok;
    logic        launch;
    logic        accept;
    logic        at_end;
    logic        wrap;

    // filter bit of a mode code, top bit flags a code that may be logged at all
    function automatic logic [5:0] mode_bit(input logic [4:0] mc, input logic bc);
        logic [5:0] r;
        r = 6'h00;
        case (mc)
            MC_SYNC:         r = {1'b1, bc ? `BML_MCB_SYNC_BC : `BML_MCB_SYNC};
            MC_SYNC_DATA:    r = {1'b1, bc ? `BML_MCB_SYNC_DATA_BC : `BML_MCB_SYNC_DATA};
            MC_SHUT,
            MC_SHUT_OVR:     r = {1'b1, bc ? `BML_MCB_SHUT_BC : `BML_MCB_SHUT};
            MC_VECTOR_WORD:  r = {!bc, `BML_MCB_VECTOR_WORD};
            MC_BIT_WORD:     r = {!bc, `BML_MCB_BIT_WORD};
            MC_BUS_CTRL:     r = {!bc, `BML_MCB_BUS_CTRL};
            MC_SELF_TEST:    r = {1'b1, bc ? `BML_MCB_SELF_TEST_BC : `BML_MCB_SELF_TEST};
            MC_FLAG_INH,
            MC_FLAG_INH_OVR: r = {1'b1, bc ? `BML_MCB_FLAG_INH_BC : `BML_MCB_FLAG_INH};
            MC_RESET:        r = {1'b1, bc ? `BML_MCB_RESET_BC : `BML_MCB_RESET};
            MC_STATUS_WORD:  r = {!bc, `BML_MCB_STATUS_WORD};
            MC_LAST_CMD:     r = {!bc, `BML_MCB_LAST_CMD};
            MC_SEL_SHUT,
            MC_SEL_SHUT_OVR: r = {1'b1, bc ? `BML_MCB_SEL_SHUT_BC : `BML_MCB_SEL_SHUT};
            default:         r = 6'h00;
        endcase
        return r;
    endfunction : mode_bit

    // register write decode
    assign wr_mode  = reg_req.wr && (reg_req.addr == `BML_OFS_MODE_FILT);
    assign wr_start = reg_req.wr && (reg_req.addr == `BML_OFS_BUF_START);
    assign wr_end   = reg_req.wr && (reg_req.addr == `BML_OFS_BUF_END);
    assign wr_pos   = reg_req.wr && (reg_req.addr == `BML_OFS_BUF_POS);
    assign wr_tt    = reg_req.wr && (reg_req.addr == `BML_OFS_TIME_TAG);

    always_ff @(posedge clk) begin
        if (!rst_n) mode_filt_ff <= `BML_MODE_FILT_RST;
        else if (wr_mode) mode_filt_ff <= reg_req.wdata[18:0];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) start_ff <= `BML_START_RST;
        else if (wr_start) start_ff <= reg_req.wdata[31:3];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) end_ff <= `BML_END_RST;
        else if (wr_end) end_ff <= reg_req.wdata[21:3];
    end

    // software write wins over a hardware advance in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) pos_ff <= `BML_POS_RST;
        else if (wr_pos) pos_ff <= reg_req.wdata[21:3];
        else if (accept) pos_ff <= at_end ? start_ff[18:0] : pos_ff + 19'h00001;
    end

    // read mux, answer one cycle after the strobe, unmapped reads zero
    always_comb begin
        nxt_rdata = 32'h00000000;
        case (reg_req.addr)
            `BML_OFS_MODE_FILT: nxt_rdata = {`BML_MODE_RSVD_RD, mode_filt_ff};
            `BML_OFS_BUF_START: nxt_rdata = {start_ff, `BML_ALIGN_LOW_RD};
            `BML_OFS_BUF_END:   nxt_rdata = {start_ff[28:19], end_ff, `BML_END_LOW_RD};
            `BML_OFS_BUF_POS:   nxt_rdata = {start_ff[28:19], pos_ff, `BML_ALIGN_LOW_RD};
            `BML_OFS_TIME_TAG:  nxt_rdata = {tt_res, tt_val};
            default:            nxt_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) reg_rdata_ff <= 32'h00000000;
        else if (reg_req.rd) reg_rdata_ff <= nxt_rdata;
        else reg_rdata_ff <= 32'h00000000;
    end

    bml_time_tag #(
        .CYC_PER_US (CYC_PER_US)
    ) u_time_tag (
        .clk      (clk),
        .rst_n    (rst_n),
        .load     (wr_tt),
        .load_res (reg_req.wdata[31:24]),
        .load_val (reg_req.wdata[23:0]),
        .res_ff   (tt_res),
        .value_ff (tt_val)
    );

    // each transfer is stamped when it enters the buffer
    assign fifo_in = '{xfer: xfer_data, tag: tt_val};

    bml_fifo #(
        .WIDTH ($bits(bml_entry_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk         (clk),
        .rst_n       (rst_n),
        .in_valid    (xfer_valid),
        .in_ready_ff (xfer_ready),
        .in_data     (fifo_in),
        .out_valid   (pop_valid),
        .out_ready   (pop_ready),
        .out_data    (pop_entry)
    );

    // entry filter
    assign is_mode = (pop_entry.xfer.sub_addr == `BML_SA_MODE_LO) || (pop_entry.xfer.sub_addr == `BML_SA_MODE_HI);
    assign bcast   = pop_entry.xfer.rt_addr == `BML_RT_BCAST;
    assign mc_sel  = mode_bit(pop_entry.xfer.mode_code, bcast);
    assign hit_rt  = terminal_address_log_filter[pop_entry.xfer.rt_addr];
    assign hit_sa  = subaddress_log_filter[pop_entry.xfer.sub_addr];
    assign hit_mc  = !is_mode || (mc_sel[5] && mode_filt_ff[mc_sel[4:0]]);
    assign log_ok  = monitor_enable && !halted_ff && hit_rt && hit_sa && hit_mc;

    // one entry in flight; filtered-out entries are simply dropped
    assign pop_ready = !mem_wr_valid_ff;
    assign pop       = pop_valid && pop_ready;
    assign launch    = pop && log_ok;
    assign accept    = mem_wr_valid_ff && mem_wr_ready;
    assign at_end    = pos_ff == end_ff;
    assign wrap      = accept && at_end && !wr_pos;

    always_ff @(posedge clk) begin
        if (!rst_n) mem_wr_valid_ff <= 1'b0;
        else if (launch) mem_wr_valid_ff <= 1'b1;
        else if (mem_wr_ready) mem_wr_valid_ff <= 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_wr_ff <= '0;
        end else if (launch) begin
            mem_wr_ff.addr <= {start_ff[28:19], pos_ff, `BML_ALIGN_LOW_RD};
            mem_wr_ff.data <= {pop_entry.xfer.word, pop_entry.tag, 3'h0, pop_entry.xfer.rt_addr};
        end
    end

    // enable clear request to the control register, one cycle pulse
    always_ff @(posedge clk) begin
        if (!rst_n) enable_clear_ff <= 1'b0;
        else enable_clear_ff <= wrap && halt_on_wrap;
    end

    // hold logging off until the control side has dropped the enable
    always_ff @(posedge clk) begin
        if (!rst_n) halted_ff <= 1'b0;
        else if (wrap && halt_on_wrap) halted_ff <= 1'b1;
        else if (!monitor_enable) halted_ff <= 1'b0;
    end

    // checking helpers
    logic       rd_q;
    logic [7:0] rd_addr_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_q      <= 1'b0;
            rd_addr_q <= 8'h00;
        end else begin
            rd_q      <= reg_req.rd;
            rd_addr_q <= reg_req.addr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_pop_last_cmd;
        pop && is_mode && !bcast && (pop_entry.xfer.mode_code == MC_LAST_CMD);
    endsequence

    sequence s_pop_bus_ctrl;
        pop && is_mode && !bcast && (pop_entry.xfer.mode_code == MC_BUS_CTRL);
    endsequence

    sequence s_wrap_halt;
        accept && at_end && !wr_pos && halt_on_wrap;
    endsequence

    sequence s_pop_bcast_sync;
        pop && is_mode && bcast && (pop_entry.xfer.mode_code == MC_SYNC);
    endsequence

    chk_start_low_zero : assert property (
        rd_q && rd_addr_q == `BML_OFS_BUF_START |-> reg_rdata_ff[2:0] == 3'h0)
        else $error("start read low bits not zero");

    chk_end_low_ones : assert property (
        rd_q && rd_addr_q == `BML_OFS_BUF_END |-> reg_rdata_ff[2:0] == 3'h7)
        else $error("end read low bits not ones");

    chk_end_high_mirror : assert property (
        rd_q && (rd_addr_q == `BML_OFS_BUF_END || rd_addr_q == `BML_OFS_BUF_POS)
        |-> reg_rdata_ff[31:22] == $past(start_ff[28:19]))
        else $error("high pointer bits differ from start");

    chk_pos_low_zero : assert property (
        rd_q && rd_addr_q == `BML_OFS_BUF_POS |-> reg_rdata_ff[2:0] == 3'h0)
        else $error("position read low bits not zero");

    chk_mode_rsvd_bits : assert property (
        rd_q && rd_addr_q == `BML_OFS_MODE_FILT |-> reg_rdata_ff[31:19] == 13'h1FFF)
        else $error("mode filter reserved bits wrong");

    chk_end_write_mask : assert property (
        wr_end |=> end_ff == $past(reg_req.wdata[21:3]))
        else $error("end pointer write not stored");

    chk_pos_write_mask : assert property (
        wr_pos |=> pos_ff == $past(reg_req.wdata[21:3]))
        else $error("position write not stored");

    chk_tt_res_read : assert property (
        reg_req.rd && reg_req.addr == `BML_OFS_TIME_TAG |=> reg_rdata_ff[31:24] == $past(tt_res))
        else $error("time resolution read wrong");

    chk_tt_value_load : assert property (
        wr_tt |=> tt_val == $past(reg_req.wdata[23:0]))
        else $error("time tag value not overwritten");

    chk_no_log_disabled : assert property (
        $rose(mem_wr_valid_ff) |-> $past(monitor_enable) && !$past(halted_ff))
        else $error("entry written while logging disabled");

    chk_addr_filter_hit : assert property (
        $rose(mem_wr_valid_ff) |-> $past(terminal_address_log_filter[pop_entry.xfer.rt_addr]))
        else $error("entry written for filtered terminal");

    chk_sa0_mode_gate : assert property (
        pop && pop_entry.xfer.sub_addr == 5'h00 && !subaddress_log_filter[0] |=> !$rose(mem_wr_valid_ff))
        else $error("subaddress 0 mode command logged while filtered");

    chk_last_cmd_gate : assert property (
        s_pop_last_cmd ##0 !mode_filt_ff[`BML_MCB_LAST_CMD] |=> !$rose(mem_wr_valid_ff))
        else $error("last command mode code logged while filtered");

    chk_bus_ctrl_gate : assert property (
        s_pop_bus_ctrl ##0 !mode_filt_ff[`BML_MCB_BUS_CTRL] |=> !$rose(mem_wr_valid_ff))
        else $error("bus control mode code logged while filtered");

    chk_ptr_step_one : assert property (
        accept && !at_end && !wr_pos |=> pos_ff == $past(pos_ff) + 19'h00001)
        else $error("position did not advance by one entry");

    chk_ptr_wrap_start : assert property (
        accept && at_end && !wr_pos |=> pos_ff == $past(start_ff[18:0]))
        else $error("position did not reload start");

    chk_wrap_stop_seq : assert property (
        s_wrap_halt |=> enable_clear_ff && halted_ff ##1 !enable_clear_ff)
        else $error("wrap stop did not halt logging");

    chk_bcast_sync_gate : assert property (
        s_pop_bcast_sync ##0 !mode_filt_ff[`BML_MCB_SYNC_BC] |=> !$rose(mem_wr_valid_ff))
        else $error("broadcast sync mode code logged while filtered");

    chk_halt_no_launch : assert property (
        halted_ff |=> !$rose(mem_wr_valid_ff))
        else $error("entry launched while halted after wrap");

    chk_entry_pos_addr : assert property (
        $rose(mem_wr_valid_ff) |-> mem_wr_ff.addr[21:0] == {$past(pos_ff), 3'h0})
        else $error("entry address differs from position");

    chk_entry_high_addr : assert property (
        $rose(mem_wr_valid_ff) |-> mem_wr_ff.addr[31:22] == $past(start_ff[28:19]))
        else $error("entry address high bits differ from start");

    chk_mode_filt_write : assert property (
        wr_mode |=> mode_filt_ff == $past(reg_req.wdata[18:0]))
        else $error("mode filter write not stored");

    chk_start_write : assert property (
        wr_start |=> start_ff == $past(reg_req.wdata[31:3]))
        else $error("start pointer write not stored");

endmodule : bml_log_config

// ===== sim/bml_mem_model.sv
// memory side model that takes log entry writes with random stalls
`timescale 1ns/1ns
module bml_mem_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic stall,
    output logic      ready
);
    integer seed = 32'h299d;
    always @(posedge clk) begin
        if (!rst_n) begin
            ready <= 1'b0;
        end else begin
            ready <= !stall && $random(seed) % 2 != 0;
        end
    end
endmodule : bml_mem_model

// ===== sim/tb.sv
// self-checking bench for the log configuration block
`timescale 1ns/1ns
module tb;
    import bml_pkg::*;
    logic         clk = 1'b0, rst_n = 1'b0, en = 1'b0, halt = 1'b0;
    logic         xv = 1'b0, stall = 1'b0, rd_seen = 1'b0;
    logic         xr, ecl, mv, mr;
    logic [31:0]  ta_f = 32'hFFFFFFDF, sa_f = 32'hFFFFFFFE, rdata, w;
    logic [23:0]  v1, tg = 24'h000001;
    bml_reg_req_t req = '0;
    bml_xfer_t    xd = '0;
    bml_memwr_t   mw;
    int           failures = 0, n_compared = 0, n_clr = 0, i, seed = 32'h299d;
    logic [63:0]  rq[$];
    logic [68:0]  mq[$];

    bml_log_config #(.FIFO_DEPTH(8), .CYC_PER_US(2)) uut (.clk(clk), .rst_n(rst_n), .reg_req(req),
        .reg_rdata_ff(rdata), .monitor_enable(en), .halt_on_wrap(halt), .terminal_address_log_filter(ta_f),
        .subaddress_log_filter(sa_f), .enable_clear_ff(ecl), .xfer_valid(xv), .xfer_data(xd),
        .xfer_ready(xr), .mem_wr_ff(mw), .mem_wr_valid_ff(mv), .mem_wr_ready(mr));
    bml_mem_model mem (.clk(clk), .rst_n(rst_n), .stall(stall), .ready(mr));

    initial forever #50 clk = ~clk;

    task automatic report_and_stop();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr

    // expected value is given already masked
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        @(posedge clk);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        rq.push_back({e, m});
        @(posedge clk);
        req.rd <= 1'b0;
    endtask : rd

    // caller stands just after a rising edge; valid is left high for back-to-back use
    task automatic send(input logic [4:0] rt, sa, mc, input logic [31:0] a, input bit log_it);
        int k;
        w = $random(seed);
        xv <= 1'b1;
        xd <= '{rt, sa, mc, w};
        for (k = 0; k < 400; k++) begin
            @(negedge clk);
            if (xr === 1'b1) break;
        end
        if (k == 400) begin
            check("xfer_ready wait", 32'h1, 32'h0);
            report_and_stop();
        end
        @(posedge clk);
        if (log_it) mq.push_back({a, w, rt});
    endtask : send

    task automatic drain();
        int k;
        for (k = 0; k < 400 && mq.size() > 0; k++) @(posedge clk);
        check("entries left", 32'h0, mq.size());
        if (mq.size() != 0) report_and_stop();
        repeat (6) @(posedge clk);
    endtask : drain

    always @(posedge clk) begin
        rd_seen <= req.rd;
        if (rd_seen) begin
            check("rdata", rq[0][63:32], rdata & rq[0][31:0]);
            void'(rq.pop_front());
        end
        if (ecl === 1'b1) n_clr++;
        if (mv === 1'b1 && mr === 1'b1) begin
            if (mq.size() == 0) begin
                check("entry count", 32'h0, 32'h1);
            end else begin
                check("entry addr", mq[0][68:37], mw.addr);
                check("entry word", mq[0][36:5], mw.data[63:32]);
                check("entry rt", {27'h0, mq[0][4:0]}, {24'h0, mw.data[7:0]});
                check("entry tag", 32'h1, {31'h0, mw.data[31:8] >= tg && mw.data[31:8] < 24'h001000});
                tg = mw.data[31:8];
                void'(mq.pop_front());
            end
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'hD0, 32'hFFFFFFFF);
        rd(8'hD4, 32'h0);
        rd(8'hD8, 32'h7);
        rd(8'hDC, 32'h0);
        rd(8'hE0, 32'h0, 32'hFF000000);
        rd(8'h10, 32'h0);
        wr(8'hD0, 32'h0);
        rd(8'hD0, 32'hFFF80000);
        wr(8'hD4, 32'hFFC00017);
        wr(8'hD8, 32'h00000028);
        wr(8'hDC, 32'h12345677);
        rd(8'hD4, 32'hFFC00010);
        rd(8'hD8, 32'hFFC0002F);
        rd(8'hDC, 32'hFFF45670);
        wr(8'hE0, 32'h01FFFFFE);
        rd(8'hE0, 32'h01000000, 32'hFF000000);
        #1 v1 = rdata[23:0];
        check("time tag load", 32'h7FFFFF, {9'h0, v1[23:1]});
        repeat (38) @(posedge clk);
        rd(8'hE0, 32'h01000000, 32'hFF000000);
        #1 check("time tag step", 32'd10, {8'h0, rdata[23:0] - v1});
        wr(8'hD4, 32'h00000100);
        wr(8'hD8, 32'h00000118);
        wr(8'hDC, 32'h00000100);
        wr(8'hD0, 32'h00008000);
        send(5'd3, 5'd1, 5'd0, 32'h0, 1'b0);
        xv <= 1'b0;
        drain();
        en <= 1'b1;
        send(5'd5, 5'd1, 5'd0, 32'h0, 1'b0);
        send(5'd3, 5'd1, 5'd0, 32'h100, 1'b1);
        send(5'd3, 5'd0, 5'd2, 32'h0, 1'b0);
        xv <= 1'b0;
        drain();
        sa_f <= '1;
        send(5'd3, 5'd0, 5'd2, 32'h108, 1'b1);
        send(5'd3, 5'd0, 5'd1, 32'h0, 1'b0);
        send(5'd3, 5'd31, 5'd8, 32'h0, 1'b0);
        send(5'd3, 5'd0, 5'd18, 32'h0, 1'b0);
        send(5'd3, 5'd31, 5'd0, 32'h0, 1'b0);
        xv <= 1'b0;
        wr(8'hD0, 32'h00002101);
        send(5'd3, 5'd0, 5'd8, 32'h110, 1'b1);
        send(5'd3, 5'd31, 5'd0, 32'h118, 1'b1);
        send(5'd3, 5'd0, 5'd1, 32'h100, 1'b1);
        send(5'd31, 5'd0, 5'd1, 32'h0, 1'b0);
        xv <= 1'b0;
        drain();
        stall <= 1'b1;
        halt <= 1'b1;
        for (i = 0; i < 20; i++) begin
            w = $random(seed);
            xv <= 1'b1;
            xd <= '{5'd3, 5'd1, 5'd0, w};
            @(negedge clk);
            if (xr !== 1'b1) break;
            @(posedge clk);
            if (i < 3) mq.push_back({32'h108 + 8 * i, w, 5'd3});
        end
        @(posedge clk);
        xv <= 1'b0;
        check("fill refused", 32'h1, {31'h0, i >= 8 && i <= 10});
        stall <= 1'b0;
        drain();
        check("clear pulses", 32'd1, n_clr);
        rd(8'hDC, 32'h100);
        repeat (3) @(posedge clk);
        report_and_stop();
    end
endmodule : tb
